// ### design/adop_output_path.sv
// Digital output path: gain, overrange, time stamp, sync status, decimation
`timescale 1ns/1ps

module adop_output_path #(
   parameter int SAMPLE_W = 14,
   parameter int DATA_LAT = adop_pkg::DATA_LAT,
   parameter int TS_LAT   = adop_pkg::TS_LAT,
   parameter int NUM_DDC  = 4
) (
   // Clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                reset_i,
   // Converter core samples, one per clock
   input  wire logic [SAMPLE_W-1:0] sample_i,
   // Sync window monitor results
   input  wire logic [4:0]          sync_window_i,
   // General pin zero
   input  wire logic                general_pin_zero_i,
   output logic                     general_pin_zero_o,
   output logic                     general_pin_zero_oe_o,
   // Serial register port
   input  wire logic                spi_csn_i,
   input  wire logic                spi_sclk_i,
   input  wire logic                spi_mosi_i,
   output logic                     spi_miso_o,
   // Output lanes
   output logic [SAMPLE_W-1:0]      dout_o,
   output logic                     dout_valid_o,
   output logic [1:0]               dout_band_o,
   output logic                     complex_mode_o
);

   localparam int W = SAMPLE_W;
   localparam logic signed [W:0] MAX_POS = (W+1)'((1 << (W-1)) - 1);
   localparam logic signed [W:0] MAX_NEG = (W+1)'(-(1 << (W-1)));

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [7:0] ovr_cfg, ovr_thr, ovr_lsb, gpio_sel, gain, out_cfg;
   logic [7:0] ratio01, ratio23, dec_cfg;
   logic       sync_edge_seen;
   logic [4:0] sync_windows;
   logic       sync_window_any;

   // ----------------------------------------------------------------
   // Serial register port, mode 0, 24-bit frame: r/w, address, data
   // ----------------------------------------------------------------
   logic        sclk_q, spi_rw, wr_pulse;
   logic [4:0]  bit_cnt;
   logic [22:0] shift_in;
   logic [14:0] spi_addr;
   logic [7:0]  rd_shift, rd_data, wr_data;
   logic        sclk_rise, sclk_fall;
   logic [14:0] rd_addr;

   // Address as it completes on the 16th rise; the registered copy lags by one
   assign rd_addr = {shift_in[13:0], spi_mosi_i};

   assign sclk_rise = spi_sclk_i & ~sclk_q & ~spi_csn_i;
   assign sclk_fall = ~spi_sclk_i & sclk_q & ~spi_csn_i;

   // Frame shifter; chip select high restarts the frame
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sclk_q   <= 1'b0;
         bit_cnt  <= 5'h00;
         shift_in <= 23'h000000;
         spi_rw   <= 1'b0;
         spi_addr <= 15'h0000;
         wr_pulse <= 1'b0;
         wr_data  <= 8'h00;
         rd_shift <= 8'h00;
         spi_miso_o <= 1'b0;
      end
      else
      begin
         sclk_q   <= spi_sclk_i;
         wr_pulse <= 1'b0;
         if (spi_csn_i)
            bit_cnt <= 5'h00;
         else if (sclk_rise)
         begin
            shift_in <= {shift_in[21:0], spi_mosi_i};
            bit_cnt  <= bit_cnt + 5'h01;
            if (bit_cnt == 5'd15)
            begin
               spi_rw   <= shift_in[14];
               spi_addr <= {shift_in[13:0], spi_mosi_i};
               rd_shift <= rd_data;
            end
            if (bit_cnt == 5'(adop_pkg::SPI_FRAME - 1))
            begin
               wr_pulse <= ~spi_rw;
               wr_data  <= {shift_in[6:0], spi_mosi_i};
            end
         end
         else if (sclk_fall && bit_cnt >= 5'd16)
         begin
            // Shift on falling edge so data is settled for the next rise
            spi_miso_o <= rd_shift[7];
            rd_shift   <= {rd_shift[6:0], 1'b0};
         end
      end
   end

   // Configuration registers written at frame end
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         ovr_cfg  <= adop_pkg::RST_OVR_CFG;
         ovr_thr  <= adop_pkg::RST_OVR_THR;
         ovr_lsb  <= adop_pkg::RST_ZERO;
         gpio_sel <= adop_pkg::RST_ZERO;
         gain     <= adop_pkg::RST_ZERO;
         out_cfg  <= adop_pkg::RST_ZERO;
         ratio01  <= adop_pkg::RST_ZERO;
         ratio23  <= adop_pkg::RST_ZERO;
         dec_cfg  <= adop_pkg::RST_ZERO;
      end
      else if (wr_pulse)
      begin
         unique case (spi_addr)
            adop_pkg::REG_OVR_CFG:     ovr_cfg  <= wr_data;
            adop_pkg::REG_OVR_THR:     ovr_thr  <= wr_data;
            adop_pkg::REG_OVR_LSB:     ovr_lsb  <= wr_data;
            adop_pkg::REG_GPIO_SEL:    gpio_sel <= wr_data;
            adop_pkg::REG_GAIN:        gain     <= wr_data;
            adop_pkg::REG_OUT_CFG:     out_cfg  <= wr_data;
            adop_pkg::REG_DDC_RATIO01: ratio01  <= wr_data;
            adop_pkg::REG_DDC_RATIO23: ratio23  <= wr_data;
            adop_pkg::REG_DEC_CFG:     dec_cfg  <= wr_data;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      unique case (rd_addr)
         adop_pkg::REG_OVR_CFG:     rd_data = ovr_cfg;
         adop_pkg::REG_OVR_THR:     rd_data = ovr_thr;
         adop_pkg::REG_OVR_LSB:     rd_data = ovr_lsb;
         adop_pkg::REG_SYNC_STATUS: rd_data = {1'b0, sync_edge_seen, sync_window_any,
                                              sync_windows};
         adop_pkg::REG_GPIO_SEL:    rd_data = gpio_sel;
         adop_pkg::REG_GAIN:        rd_data = gain;
         adop_pkg::REG_OUT_CFG:     rd_data = out_cfg;
         adop_pkg::REG_DDC_RATIO01: rd_data = ratio01;
         adop_pkg::REG_DDC_RATIO23: rd_data = ratio23;
         adop_pkg::REG_DEC_CFG:     rd_data = dec_cfg;
         default:                   rd_data = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Sync edge capture and window status
   // ----------------------------------------------------------------
   logic sync_in, sync_q, sync_rise, bypass, ts_active, status_clr;

   assign sync_in    = (gpio_sel[1:0] == adop_pkg::GPIO_SYNC_IN) & general_pin_zero_i;
   assign sync_rise  = sync_in & ~sync_q;
   assign bypass     = (dec_cfg[3:0] == 4'h0);
   assign ts_active  = bypass & (out_cfg[7:6] == adop_pkg::TS_ENABLE_CODE);
   assign status_clr = wr_pulse & (spi_addr == adop_pkg::REG_SYNC_STATUS)
                       & wr_data[adop_pkg::EDGE_SEEN_BIT];
   assign sync_window_any = |sync_windows;

   // Set beats clear so an edge in the clearing cycle is not lost
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sync_q         <= 1'b0;
         sync_edge_seen <= 1'b0;
         sync_windows   <= 5'h00;
      end
      else
      begin
         sync_q <= sync_in;
         if (sync_rise)
         begin
            sync_edge_seen <= 1'b1;
            sync_windows   <= sync_window_i;
         end
         else if (status_clr)
            sync_edge_seen <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Digital gain and overrange detection
   // ----------------------------------------------------------------
   logic signed [W+7:0] gain_prod;
   logic signed [W+1:0] gain_sum;
   logic signed [W-1:0] gain_sat;
   logic [W-1:0]        gain_mag, thr_level;
   logic                gain_clip, ovr_now;
   logic [W:0]          gw_q;

   // Factor is 1 + g/128; the product term is truncated toward minus infinity
   assign gain_prod = $signed(sample_i) * $signed(gain);
   assign gain_sum  = {{2{sample_i[W-1]}}, sample_i}
                      + {gain_prod[W+7], gain_prod[W+7:adop_pkg::GAIN_SHIFT]};
   assign gain_clip = (gain_sum > MAX_POS) | (gain_sum < MAX_NEG);
   assign gain_sat  = (gain_sum > MAX_POS) ? W'(MAX_POS)
                    : (gain_sum < MAX_NEG) ? W'(MAX_NEG) : W'(gain_sum);
   assign gain_mag  = gain_sat[W-1] ? W'(-gain_sat) : W'(gain_sat);
   assign thr_level = W'({ovr_thr[6:0], 6'h3F});
   assign ovr_now   = ovr_cfg[0] & (gain_clip | (gain_mag >= thr_level));

   // Overrange rides with its sample so the latencies match
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         gw_q <= '0;
      else
         gw_q <= {ovr_now, gain_sat};
   end

   // ----------------------------------------------------------------
   // Bypass delay line and time stamp marker line
   // ----------------------------------------------------------------
   logic [W:0]        dline [DATA_LAT-2];
   logic [TS_LAT-2:0] mark_line;
   logic [W:0]        byp_word;

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < DATA_LAT-2; i++)
            dline[i] <= '0;
         mark_line <= '0;
      end
      else
      begin
         dline[0] <= gw_q;
         for (int i = 1; i < DATA_LAT-2; i++)
            dline[i] <= dline[i-1];
         // Marker takes its own short path, so it leads the sample
         mark_line <= {mark_line[TS_LAT-3:0], sync_rise & ts_active};
      end
   end

   assign byp_word = dline[DATA_LAT-3];

   // ----------------------------------------------------------------
   // Downconverter ratio selection and slot timing
   // ----------------------------------------------------------------
   logic [1:0]  band_mode;
   logic [2:0]  num_bands;
   logic [3:0]  code_min, code_max;
   logic [3:0]  band_code [NUM_DDC];
   logic        band_wrap [NUM_DDC];
   logic [W:0]  band_hold [NUM_DDC];
   logic [1:0]  min_idx;
   logic        seq_busy;
   logic [1:0]  seq_idx;

   assign band_mode = dec_cfg[5:4];

   // Band count picks the legal ratio span
   always_comb
   begin
      unique case (band_mode)
         adop_pkg::BANDS_SINGLE:
         begin
            num_bands = 3'd1;
            code_min  = adop_pkg::CODE_MIN_SINGLE;
            code_max  = adop_pkg::CODE_MAX_SINGLE;
         end
         adop_pkg::BANDS_DUAL:
         begin
            num_bands = 3'd2;
            code_min  = adop_pkg::CODE_MIN_DUAL;
            code_max  = adop_pkg::CODE_MAX_DUAL;
         end
         default:
         begin
            num_bands = 3'(NUM_DDC);
            code_min  = adop_pkg::CODE_MIN_QUAD;
            code_max  = adop_pkg::CODE_MAX_QUAD;
         end
      endcase
   end

   // One counter per downconverter; sample held at each decimated instant
   for (genvar b = 0; b < NUM_DDC; b++)
   begin : g_band
      logic [3:0]  own;
      logic [3:0]  raw;
      logic [14:0] cnt;
      logic [14:0] last;
      assign own  = (b < 2) ? ratio01[4*(b%2) +: 4] : ratio23[4*(b%2) +: 4];
      assign raw  = (own != 4'h0) ? own : dec_cfg[3:0];
      assign band_code[b] = (raw < code_min) ? code_min
                          : (raw > code_max) ? code_max : raw;
      assign last = 15'((16'h0001 << band_code[b]) - 16'h0001);
      assign band_wrap[b] = (cnt == last);

      always_ff @(posedge sys_clk_i)
      begin
         if (reset_i || bypass)
         begin
            cnt          <= 15'h0000;
            band_hold[b] <= '0;
         end
         else
         begin
            cnt <= band_wrap[b] ? 15'h0000 : cnt + 15'h0001;
            if (band_wrap[b])
               band_hold[b] <= gw_q;
         end
      end
   end

   // Fastest active band sets the slot rate
   always_comb
   begin
      min_idx = 2'd0;
      for (int b = 1; b < NUM_DDC; b++)
         if (3'(b) < num_bands && band_code[b] < band_code[min_idx])
            min_idx = 2'(b);
   end

   // Slot sequencer emits every active band once per fastest-band sample
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || bypass)
      begin
         seq_busy <= 1'b0;
         seq_idx  <= 2'd0;
      end
      else if (band_wrap[min_idx])
      begin
         seq_busy <= 1'b1;
         seq_idx  <= 2'd0;
      end
      else if (seq_busy)
      begin
         seq_busy <= (3'(seq_idx) + 3'd1 < num_bands);
         seq_idx  <= seq_idx + 2'd1;
      end
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   logic [W:0] slot_word;
   assign slot_word = band_hold[seq_idx];

   // Repeated slots for slower bands reuse their held sample
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         dout_o         <= '0;
         dout_valid_o   <= 1'b0;
         dout_band_o    <= 2'd0;
         complex_mode_o <= 1'b0;
      end
      else
      begin
         // Real output only in single band; complex elsewhere or on request
         complex_mode_o <= out_cfg[adop_pkg::COMPLEX_BIT] | (num_bands > 3'd1);
         if (bypass)
         begin
            dout_valid_o <= 1'b1;
            dout_band_o  <= 2'd0;
            dout_o       <= byp_word[W-1:0];
            if (ts_active)
               dout_o[0] <= mark_line[TS_LAT-2];
            else if (ovr_lsb[0])
               dout_o[0] <= byp_word[W];
         end
         else
         begin
            dout_valid_o <= seq_busy;
            dout_band_o  <= seq_idx;
            dout_o       <= {slot_word[W-1:1], ovr_lsb[0] ? slot_word[W] : slot_word[0]};
         end
      end
   end

   // Pin carries overrange on select code 1, listens for sync on code 0, and does neither otherwise
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         general_pin_zero_o    <= 1'b0;
         general_pin_zero_oe_o <= 1'b0;
      end
      else
      begin
         general_pin_zero_oe_o <= (gpio_sel[1:0] == adop_pkg::GPIO_OVR_OUT);
         general_pin_zero_o    <= byp_word[W];
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   localparam int C_TS = TS_LAT;

   property p_ts_lat;
      @(posedge sys_clk_i) disable iff (reset_i)
      (sync_rise && ts_active) ##1 (ts_active [*7]) |=> dout_o[0];
   endproperty
   a_ts_lat: assert property (p_ts_lat) else $error("marker late or missing");

   property p_edge_set;
      @(posedge sys_clk_i) disable iff (reset_i)
      sync_rise |=> sync_edge_seen && (sync_windows == $past(sync_window_i));
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("sync edge not recorded");

   property p_edge_sticky;
      @(posedge sys_clk_i) disable iff (reset_i)
      (sync_edge_seen && !status_clr) |=> sync_edge_seen;
   endproperty
   a_edge_sticky: assert property (p_edge_sticky) else $error("edge flag dropped");

   property p_ovr_clip;
      @(posedge sys_clk_i) disable iff (reset_i)
      (gain_clip && ovr_cfg[0]) |=> gw_q[W];
   endproperty
   a_ovr_clip: assert property (p_ovr_clip) else $error("overrange missed");

   property p_ovr_path;
      @(posedge sys_clk_i) disable iff (reset_i)
      bypass && !$past(reset_i, DATA_LAT-2) |-> byp_word == $past(gw_q, DATA_LAT-2);
   endproperty
   a_ovr_path: assert property (p_ovr_path) else $error("data delay wrong");

   property p_quad_span;
      @(posedge sys_clk_i) disable iff (reset_i)
      (num_bands == 3'd4) |-> band_code[0] >= 4'h3 && band_code[0] <= 4'hC;
   endproperty
   a_quad_span: assert property (p_quad_span) else $error("quad ratio out of span");

   property p_real_single;
      @(posedge sys_clk_i) disable iff (reset_i)
      (num_bands != 3'd1) |=> complex_mode_o;
   endproperty
   a_real_single: assert property (p_real_single) else $error("real output multi band");

   property p_pin_ovr;
      @(posedge sys_clk_i) disable iff (reset_i)
      (gpio_sel[1:0] == adop_pkg::GPIO_OVR_OUT) |=> general_pin_zero_oe_o
         && general_pin_zero_o == $past(byp_word[W]);
   endproperty
   a_pin_ovr: assert property (p_pin_ovr) else $error("pin not driving overrange");

   property p_no_ts_ddc;
      @(posedge sys_clk_i) disable iff (reset_i)
      !bypass |-> !ts_active;
   endproperty
   a_no_ts_ddc: assert property (p_no_ts_ddc) else $error("stamp active in ddc");

   c_marker:  cover property (@(posedge sys_clk_i) ts_active && mark_line[TS_LAT-2]);
   c_ddc_out: cover property (@(posedge sys_clk_i) !bypass && dout_valid_o && dout_band_o == 2'd3);
   c_edge:    cover property (@(posedge sys_clk_i) sync_rise && status_clr);

endmodule : adop_output_path

// ### design/adop_pkg.sv
// Constants shared by the converter digital output path
package adop_pkg;

   // ----------------------------------------------------------------
   // Register offsets (serial port address space)
   // ----------------------------------------------------------------
   localparam logic [14:0] REG_OVR_CFG     = 15'h010A;
   localparam logic [14:0] REG_OVR_THR     = 15'h010B;
   localparam logic [14:0] REG_OVR_LSB     = 15'h0116;
   localparam logic [14:0] REG_SYNC_STATUS = 15'h0140;
   localparam logic [14:0] REG_GPIO_SEL    = 15'h0146;
   localparam logic [14:0] REG_GAIN        = 15'h015B;
   localparam logic [14:0] REG_OUT_CFG     = 15'h0162;
   localparam logic [14:0] REG_DDC_RATIO01 = 15'h0167;
   localparam logic [14:0] REG_DDC_RATIO23 = 15'h0168;
   localparam logic [14:0] REG_DEC_CFG     = 15'h0169;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_OVR_CFG  = 8'h01;
   localparam logic [7:0] RST_OVR_THR  = 8'h7F;
   localparam logic [7:0] RST_ZERO     = 8'h00;

   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int          EDGE_SEEN_BIT  = 6;
   localparam int          COMPLEX_BIT    = 2;
   localparam logic [1:0]  TS_ENABLE_CODE = 2'h3;
   localparam logic [1:0]  GPIO_SYNC_IN   = 2'h0;
   localparam logic [1:0]  GPIO_OVR_OUT   = 2'h1;
   localparam logic [1:0]  BANDS_SINGLE   = 2'h0;
   localparam logic [1:0]  BANDS_DUAL     = 2'h2;

   // Decimation ratio is 2 to the power of the code
   localparam logic [3:0]  CODE_MIN_SINGLE = 4'h1;
   localparam logic [3:0]  CODE_MAX_SINGLE = 4'hF;
   localparam logic [3:0]  CODE_MIN_DUAL   = 4'h2;
   localparam logic [3:0]  CODE_MAX_DUAL   = 4'hF;
   localparam logic [3:0]  CODE_MIN_QUAD   = 4'h3;
   localparam logic [3:0]  CODE_MAX_QUAD   = 4'hC;

   // ----------------------------------------------------------------
   // Latencies in sampling clock cycles; gain shift and serial frame length in bits
   // ----------------------------------------------------------------
   localparam int DATA_LAT   = 43;
   localparam int TS_LAT     = 8;
   localparam int GAIN_SHIFT = 7;
   localparam int SPI_FRAME  = 24;

endpackage : adop_pkg

// ### verif/adop_lvds_rx.sv
// Receiving logic model that counts valid output words, in total and for band 0
`timescale 1ns/1ps
module adop_lvds_rx (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   // Lane qualifiers from the device
   input  wire logic        dout_valid_i,
   input  wire logic [1:0]  dout_band_i,
   // Count window control and results
   input  wire logic        clear_i,
   output logic [15:0]      total_o,
   output logic [15:0]      band0_o
);
   // Lanes run on the sampling clock, so every valid slot is one word
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i || clear_i)
      begin
         total_o <= 16'h0000;
         band0_o <= 16'h0000;
      end
      else if (dout_valid_i)
      begin
         total_o <= total_o + 16'h0001;
         band0_o <= band0_o + {15'h0000, dout_band_i == 2'h0};
      end
   end
endmodule : adop_lvds_rx

// ### verif/adc_digital_output_path_tb_top.sv
// Self-checking bench for the converter digital output path
`timescale 1ns/1ps
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         fail_count++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
      end \
   end
module adc_digital_output_path_tb_top;
   typedef struct {logic [7:0] g; logic [13:0] x; logic [13:0] y;} adop_row_t;
   // Stimulus and observed signals
   logic        sys_clk_i = 1'b0, reset_i = 1'b1, general_pin_zero_i = 1'b0;
   logic [13:0] sample_i = 14'h0000;
   logic [4:0]  sync_window_i = 5'h00;
   logic        spi_csn_i = 1'b1, spi_sclk_i = 1'b0, spi_mosi_i = 1'b0;
   logic        spi_miso_o, general_pin_zero_o, general_pin_zero_oe_o;
   logic        dout_valid_o, complex_mode_o, rx_clr = 1'b1;
   logic [13:0] dout_o;
   logic [1:0]  dout_band_o;
   logic [15:0] rx_total, rx_band0;
   logic [7:0]  q;
   int          fail_count = 0;
   int          comparisons = 0;
   // Gain, input sample, expected output word
   adop_row_t rows [5] = '{'{8'h00, 14'h0064, 14'h0064}, '{8'h7F, 14'h03E8, 14'h07C8},
      '{8'hC0, 14'h03E8, 14'h01F4}, '{8'h7F, 14'h3C18, 14'h3837},
      '{8'h7F, 14'h1FFF, 14'h1FFF}};

   always #12.5 sys_clk_i = ~sys_clk_i;

   adop_output_path dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .sample_i(sample_i),
      .sync_window_i(sync_window_i), .general_pin_zero_i(general_pin_zero_i),
      .general_pin_zero_o(general_pin_zero_o), .general_pin_zero_oe_o(general_pin_zero_oe_o),
      .spi_csn_i(spi_csn_i), .spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i),
      .spi_miso_o(spi_miso_o), .dout_o(dout_o), .dout_valid_o(dout_valid_o),
      .dout_band_o(dout_band_o), .complex_mode_o(complex_mode_o));
   adop_lvds_rx rx_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .dout_valid_i(dout_valid_o),
      .dout_band_i(dout_band_o), .clear_i(rx_clr), .total_o(rx_total), .band0_o(rx_band0));

   // Inputs move 1 ns after the edge so the design never races them
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick

   // Serial frame; sclk levels last two clocks as the sampler needs
   task automatic spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {rw, a, d};
      q = 8'h00;
      spi_csn_i = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         spi_mosi_i = f[i];
         tick(2);
         if (i < 8) q = {q[6:0], spi_miso_o};
         spi_sclk_i = 1'b1;
         tick(2);
         spi_sclk_i = 1'b0;
      end
      tick(1);
      spi_csn_i = 1'b1;
      tick(4);
   endtask : spi

   // One-clock sample then zeros, so only that word can show later
   task automatic pulse(input logic [13:0] x, input int n);
      sample_i = x;
      tick(1);
      sample_i = 14'h0000;
      tick(n);
   endtask : pulse

   // Count valid slots over 64 clocks in a steady mode
   task automatic ddc(input logic [7:0] c, input logic [15:0] t, input logic [15:0] b);
      spi(1'b0, adop_pkg::REG_DEC_CFG, c);
      tick(16);
      rx_clr = 1'b0;
      tick(64);
      rx_clr = 1'b1;
      `CHK(rx_total, t)
      `CHK(rx_band0, b)
      $display("test ddc %h done", c);
   endtask : ddc

   task automatic stop_test;
      $display("counts: comparisons=%0d mismatches=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   // Hang guard
   initial
   begin
      #2000000;
      fail_count++;
      stop_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      tick(8);
      `CHK(dout_o, 14'h0000)
      reset_i = 1'b0;
      spi(1'b1, adop_pkg::REG_SYNC_STATUS, 8'h00);
      `CHK(q, 8'h00)
      spi(1'b1, 15'h0050, 8'h00);
      `CHK(q, 8'h00)
      $display("test reset done");
      foreach (rows[i])
      begin
         spi(1'b0, adop_pkg::REG_GAIN, rows[i].g);
         spi(1'b1, adop_pkg::REG_GAIN, 8'h00);
         `CHK(q, rows[i].g)
         pulse(rows[i].x, 41);
         `CHK(dout_o, 14'h0000)
         tick(1);
         `CHK(dout_o, rows[i].y)
      end
      $display("test gain done");
      spi(1'b0, adop_pkg::REG_GPIO_SEL, 8'h00);
      spi(1'b0, adop_pkg::REG_OUT_CFG, 8'hC0);
      sync_window_i = 5'h02;
      general_pin_zero_i = 1'b1;
      tick(8);
      `CHK(dout_o[0], 1'b1)
      tick(1);
      `CHK(dout_o[0], 1'b0)
      general_pin_zero_i = 1'b0;
      spi(1'b1, adop_pkg::REG_SYNC_STATUS, 8'h00);
      `CHK(q, 8'h62)
      spi(1'b0, adop_pkg::REG_SYNC_STATUS, 8'h40);
      spi(1'b1, adop_pkg::REG_SYNC_STATUS, 8'h00);
      `CHK(q, 8'h22)
      $display("test time stamp done");
      spi(1'b0, adop_pkg::REG_OUT_CFG, 8'h00);
      spi(1'b0, adop_pkg::REG_GAIN, 8'h00);
      spi(1'b0, adop_pkg::REG_OVR_LSB, 8'h01);
      spi(1'b0, adop_pkg::REG_GPIO_SEL, 8'h01);
      `CHK(general_pin_zero_oe_o, 1'b1)
      pulse(14'h2000, 42);
      `CHK(dout_o, 14'h2001)
      `CHK(general_pin_zero_o, 1'b1)
      tick(1);
      spi(1'b0, adop_pkg::REG_OVR_CFG, 8'h00);
      pulse(14'h2000, 42);
      `CHK(general_pin_zero_o, 1'b0)
      `CHK(dout_o, 14'h2000)
      spi(1'b0, adop_pkg::REG_OVR_CFG, 8'h01);
      spi(1'b0, adop_pkg::REG_OVR_THR, 8'h40);
      pulse(14'h1100, 42);
      `CHK(dout_o, 14'h1101)
      spi(1'b0, adop_pkg::REG_OVR_LSB, 8'h00);
      $display("test overrange done");
      ddc(8'h01, 16'd32, 16'd32);
      `CHK(complex_mode_o, 1'b0)
      ddc(8'h21, 16'd32, 16'd16);
      ddc(8'h11, 16'd32, 16'd8);
      spi(1'b0, adop_pkg::REG_GPIO_SEL, 8'h00);
      spi(1'b0, adop_pkg::REG_DEC_CFG, 8'h01);
      spi(1'b0, adop_pkg::REG_OUT_CFG, 8'hC4);
      `CHK(complex_mode_o, 1'b1)
      general_pin_zero_i = 1'b1;
      tick(8);
      `CHK(dout_o[0], 1'b0)
      general_pin_zero_i = 1'b0;
      ddc(8'h00, 16'd64, 16'd64);
      stop_test();
   end
endmodule : adc_digital_output_path_tb_top
